/* File: fcc_top.sv */
// Flash charge control: converter sequencing, done, gate and trim
`timescale 1ns/1ps

// What this block does
// - Charge request starts repeated switching cycles
// - Switch on until current limit, then off
// - Sample end-of-charge only during switch off
// - Eight threshold crossings pull completion low
// - Dropping request releases completion high
// - Gate driver off until pump reaches 4V
// - Trim programming only after unlock sequence
// - Unlocked trim writes code into OTP
// - Blown lock fuse forbids trim until reset
// - Each request restarts pump timeout timer
// - Timer stopped at reset, stops when expired
module fcc_top
	import fcc_pkg::*;
#(
	parameter logic [31:0] TIMEOUT = 32'(TIMEOUT_CYC)
) (
	// Clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rstn_in,
	// Host pins
	input  wire logic              charge_request_in,
	input  wire logic              flash_fire_in,
	output logic                   charge_complete_n_out,
	output logic                   charge_complete_n_oe_out,
	// Analog interface
	input  wire logic              current_limit_in,
	input  wire logic              eoc_compare_in,
	input  wire logic              pump_good_in,
	output logic                   switch_on_out,
	output logic                   pump_enable_out,
	output logic                   switch_gate_drive_out,
	output logic [TRIM_W-1:0]      trim_code_out,
	// AXI4-Lite write address
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// AXI4-Lite write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// Interrupt
	output logic                   irq_out
);

	////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		fcc_conv_t          cv;        // Converter state
		logic [7:0]         off_cnt;   // Off-time counter
		logic [3:0]         eoc_cnt;   // Threshold crossings seen
		logic               done;      // Completion latched
		logic               req_q;     // Previous request level
		logic               gate;      // Gate drive register
		logic               unlocked;  // Trim unlocked
		logic               fused;     // Lock fuse blown
		logic [TRIM_W-1:0]  otp;       // Programmed trim code
		logic               otp_done;  // OTP written once
		logic [IRQ_W-1:0]   ist;       // Sticky interrupt status
		logic [IRQ_W-1:0]   imask;     // Interrupt mask
		logic               aw_got;    // Write address held
		logic [ADDR_W-1:0]  aw_addr;
		logic               w_got;     // Write data held
		logic [DATA_W-1:0]  w_data;
		logic [3:0]         w_strb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [DATA_W-1:0]  rdata;
		logic [1:0]         rresp;
	} fcc_state_t;

	fcc_state_t s_q, s_d;

	// Timer interface
	logic restart;                     // Request rising edge
	logic pump_on;                     // Timer running
	logic expire;                      // Timer expired pulse

	// Write handshake helpers
	logic wr_fire;                     // Write executes now
	logic [IRQ_W-1:0] ist_set;         // Events this cycle

	////////////////////////////////////////////////////////////////////
	// Read mux decode, used by read path
	function automatic logic [DATA_W+1:0] reg_read(
		input fcc_state_t   st,
		input logic [ADDR_W-1:0] a,
		input logic         pon
	);
		logic [DATA_W-1:0] d;
		logic [1:0]        r;
		d = '0;
		r = RESP_OKAY;
		case (a)
			OFS_CTRL: begin
				d[CTRL_LOCK_BIT] = st.fused;
			end
			OFS_STATUS: begin
				d[ST_CHARGING] = (st.cv != CV_IDLE);
				d[ST_DONE]     = st.done;
				d[ST_GATE_EN]  = pon & pump_good_in;
				d[ST_PUMP_ON]  = pon;
				d[ST_UNLOCKED] = st.unlocked;
				d[ST_FUSED]    = st.fused;
				d[ST_EOC_LSB +: 4] = st.eoc_cnt;
			end
			OFS_IRQ_STAT: begin
				d[IRQ_W-1:0] = st.ist;
			end
			OFS_IRQ_MASK: begin
				d[IRQ_W-1:0] = st.imask;
			end
			OFS_TRIM: begin
				d[TRIM_W-1:0] = st.otp;
			end
			OFS_UNLOCK: begin
				d = '0;
			end
			default: begin
				r = RESP_SLVERR;
			end
		endcase
		return {r, d};
	endfunction : reg_read

	////////////////////////////////////////////////////////////////////
	// Inactivity timer for the charge pump
	fcc_timer #(
		.TIMEOUT     (TIMEOUT)
	) u_timer (
		.mclk_in     (mclk_in),
		.rstn_in     (rstn_in),
		.restart_in  (restart),
		.pump_on_out (pump_on),
		.expire_out  (expire)
	);

	// Restart on each rising request
	assign restart = charge_request_in & ~s_q.req_q;

	// A write executes once address and data are both held
	assign wr_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid;

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic [DATA_W+1:0] rd;
		rd       = '0;
		s_d      = s_q;
		ist_set  = '0;
		s_d.req_q = charge_request_in;

		// Converter sequencing
		case (s_q.cv)
			CV_IDLE: begin
				if (charge_request_in && !s_q.done) begin
					s_d.cv = CV_ON;
				end
			end
			CV_ON: begin
				if (!charge_request_in) begin
					s_d.cv = CV_IDLE;
				end else if (current_limit_in) begin
					s_d.cv      = CV_OFF;
					s_d.off_cnt = '0;
				end
			end
			CV_OFF: begin
				if (!charge_request_in) begin
					s_d.cv = CV_IDLE;
				end else if (s_q.off_cnt ==
					8'(OFF_CYC - 1)) begin
					// Sample threshold only in off time
					if (eoc_compare_in) begin
						if (s_q.eoc_cnt == EOC_COUNT - 4'h1) begin
							s_d.done = 1'b1;
							s_d.cv   = CV_IDLE;
							ist_set[IRQ_DONE] = 1'b1;
						end
						s_d.eoc_cnt = s_q.eoc_cnt + 4'h1;
					end
					if (s_d.cv != CV_IDLE) begin
						s_d.cv = CV_ON;
					end
				end else begin
					s_d.off_cnt = s_q.off_cnt + 8'h1;
				end
			end
			default: begin
				s_d.cv = CV_IDLE;
			end
		endcase

		// Request low releases completion and restarts counting
		if (!charge_request_in) begin
			s_d.done    = 1'b0;
			s_d.eoc_cnt = '0;
		end

		// Gate follows fire only while enabled
		s_d.gate = pump_on & pump_good_in & flash_fire_in;

		if (expire) begin
			ist_set[IRQ_TIMEOUT] = 1'b1;
		end

		// Write channel capture
		if (s_axi_awvalid && !s_q.aw_got) begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got) begin
			s_d.w_got  = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end

		// Write execution
		if (wr_fire) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			case (s_q.aw_addr)
				OFS_CTRL: begin
					if (s_q.w_strb[0]) begin
						if (s_q.w_data[CTRL_PROG_BIT] &&
							s_q.unlocked && !s_q.otp_done) begin
							s_d.otp_done = 1'b1;
							ist_set[IRQ_TRIMMED] = 1'b1;
						end
						if (s_q.w_data[CTRL_LOCK_BIT] &&
							s_q.unlocked) begin
							s_d.fused    = 1'b1;
							s_d.unlocked = 1'b0;
						end
					end
				end
				OFS_IRQ_STAT: begin
					if (s_q.w_strb[0]) begin
						s_d.ist = s_q.ist & ~s_q.w_data[IRQ_W-1:0];
					end
				end
				OFS_IRQ_MASK: begin
					if (s_q.w_strb[0]) begin
						s_d.imask = s_q.w_data[IRQ_W-1:0];
					end
				end
				OFS_TRIM: begin
					// Code accepted only while unlocked
					if (s_q.w_strb[0] && s_q.unlocked &&
						!s_q.otp_done) begin
						s_d.otp = s_q.w_data[TRIM_W-1:0];
					end
				end
				OFS_UNLOCK: begin
					if (s_q.w_strb == 4'hF && !s_q.fused) begin
						s_d.unlocked =
							(s_q.w_data == UNLOCK_KEY);
					end
				end
				OFS_STATUS: begin
					s_d.bresp = RESP_OKAY;
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
		end

		// Events win over clears
		s_d.ist = s_d.ist | ist_set;

		// Read channel
		if (s_axi_arvalid && !s_q.rvalid) begin
			rd        = reg_read(s_q, s_axi_araddr, pump_on);
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd[DATA_W-1:0];
			s_d.rresp  = rd[DATA_W+1:DATA_W];
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q       <= '0;
			s_q.cv    <= CV_IDLE;
			s_q.otp   <= TRIM_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign switch_on_out            = (s_q.cv == CV_ON);
	assign charge_complete_n_out    = 1'b0;
	assign charge_complete_n_oe_out = s_q.done;
	assign pump_enable_out          = pump_on;
	assign switch_gate_drive_out    = s_q.gate;
	assign trim_code_out            = s_q.otp;
	assign irq_out                  = |(s_q.ist & s_q.imask);

	// Bus handshakes
	assign s_axi_awready = ~s_q.aw_got;
	assign s_axi_wready  = ~s_q.w_got;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = ~s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	////////////////////////////////////////////////////////////////////
	// Checks
	chk_start_on_req: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		(s_q.cv == CV_IDLE && charge_request_in && !s_q.done)
		|=> s_q.cv == CV_ON)
		else $error("charge request did not start switching");

	chk_limit_ends_on: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		(switch_on_out && current_limit_in && charge_request_in)
		|=> !switch_on_out ##1 !switch_on_out)
		else $error("switch stayed on past current limit");

	chk_count_in_off: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		($past(s_q.cv) != CV_OFF && charge_request_in &&
		$past(charge_request_in))
		|-> s_q.eoc_cnt == $past(s_q.eoc_cnt))
		else $error("threshold counted outside off time");

	chk_done_at_eight: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		$rose(s_q.done) |-> $past(s_q.eoc_cnt) == EOC_COUNT - 4'h1)
		else $error("completion not at eighth crossing");

	chk_done_release: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		(s_q.done && !charge_request_in) |=> !charge_complete_n_oe_out)
		else $error("completion not released");

	chk_gate_gated: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		switch_gate_drive_out |-> $past(pump_on) && $past(pump_good_in))
		else $error("gate driven without pump");

	chk_gate_follow: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		(pump_on && pump_good_in && flash_fire_in)
		|=> switch_gate_drive_out)
		else $error("gate does not follow fire");

	chk_trim_locked: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		!s_q.unlocked |=> s_q.otp == $past(s_q.otp))
		else $error("trim changed while locked");

	chk_fuse_blocks: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		s_q.fused |=> (s_q.fused && !s_q.unlocked))
		else $error("trim mode entered after fuse");

	chk_idle_no_sw: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		!charge_request_in |=> !switch_on_out)
		else $error("switching without request");

endmodule : fcc_top

/* File: fcc_pkg.sv */
// Package: constants, states and register map of the flash charge control
package fcc_pkg;

	// Bus geometry
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;

	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
	localparam logic [7:0]  OFS_TRIM      = 8'h10;
	localparam logic [7:0]  OFS_UNLOCK    = 8'h14;

	// Control register fields
	localparam int          CTRL_PROG_BIT = 0;
	localparam int          CTRL_LOCK_BIT = 1;

	// Status register fields
	localparam int          ST_CHARGING   = 0;
	localparam int          ST_DONE       = 1;
	localparam int          ST_GATE_EN    = 2;
	localparam int          ST_PUMP_ON    = 3;
	localparam int          ST_UNLOCKED   = 4;
	localparam int          ST_FUSED      = 5;
	localparam int          ST_EOC_LSB    = 8;

	// Interrupt bits
	localparam int          IRQ_W         = 3;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_TIMEOUT   = 1;
	localparam int          IRQ_TRIMMED   = 2;

	// Trim code width and reset value
	localparam int          TRIM_W        = 5;
	localparam logic [4:0]  TRIM_RST      = 5'h10;

	// Unlock key value (arbitrary)
	localparam logic [31:0] UNLOCK_KEY    = 32'h7A5E_C3D1;

	// End of charge detections needed
	localparam logic [3:0]  EOC_COUNT     = 4'h8;

	// Clock and timing
	localparam int          CLK_MHZ       = 100;
	localparam int          OFF_NS        = 200;
	localparam int          OFF_CYC       = (OFF_NS * CLK_MHZ) / 1000;
	localparam int          TIMEOUT_S     = 20;
	localparam longint      TIMEOUT_CYC   = longint'(TIMEOUT_S) * 100_000_000;

	// Response codes
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Converter states, one-hot
	typedef enum logic [2:0] {
		CV_IDLE = 3'b001,
		CV_ON   = 3'b010,
		CV_OFF  = 3'b100
	} fcc_conv_t;

endpackage : fcc_pkg

/* File: fcc_timer.sv */
// Charge pump inactivity timeout timer
`timescale 1ns/1ps
module fcc_timer
	import fcc_pkg::*;
#(
	parameter logic [31:0] TIMEOUT = 32'(TIMEOUT_CYC)
) (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rstn_in,
	// Control
	input  wire logic restart_in,
	// Status
	output logic      pump_on_out,
	output logic      expire_out
);

	// Timer state
	typedef struct packed {
		logic [31:0] cnt;
		logic        run;
		logic        exp;
	} fcc_tmr_t;

	fcc_tmr_t s_q, s_d;

	////////////////////////////////////////////////////////////////////
	// Next state: restart on request, stop on expiry
	always_comb begin
		s_d     = s_q;
		s_d.exp = 1'b0;
		if (restart_in) begin
			s_d.run = 1'b1;
			s_d.cnt = '0;
		end else if (s_q.run) begin
			if (s_q.cnt >= TIMEOUT - 32'h1) begin
				s_d.run = 1'b0;
				s_d.exp = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 32'h1;
			end
		end
	end

	// Registers; held stopped after reset
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign pump_on_out = s_q.run;
	assign expire_out  = s_q.exp;

	// Stopped timer stays stopped without a restart
	chk_timer_stays_off: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		(!s_q.run && !restart_in) |=> !s_q.run)
		else $error("timer ran without restart");

	// Restart starts the pump
	chk_restart_runs: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		restart_in |=> (s_q.run && s_q.cnt == 32'h0))
		else $error("restart did not reload timer");

endmodule : fcc_timer

/* File: fcc_analog_model.sv */
// Partner model: converter, comparator and charge pump seen by the logic
`timescale 1ns/1ps
module fcc_analog_model (
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	// From the control logic
	input  wire logic       switch_on_in,
	input  wire logic       pump_enable_in,
	// Scenario knobs
	input  wire logic       slow_in,
	input  wire logic [7:0] target_in,
	// Towards the control logic
	output logic            current_limit_out,
	output logic            eoc_compare_out,
	output logic            pump_good_out
);
	logic [3:0] on_cnt;   // Cycles since switch closed
	logic [7:0] pulses;   // Switching pulses seen so far
	logic [4:0] pump_sh;  // Pump ramp delay line
	logic       sw_prev;  // Switch level one cycle ago

	// Current ramps while switch closed, limit after 2 or 6 cycles
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			on_cnt  <= 4'h0;
			pulses  <= 8'h00;
			pump_sh <= 5'h00;
			sw_prev <= 1'b0;
		end else begin
			sw_prev <= switch_on_in;
			on_cnt  <= switch_on_in ? on_cnt + 4'h1 : 4'h0;
			// Count each new closing of the switch
			if (switch_on_in && !sw_prev)
				pulses <= pulses + 8'h01;
			pump_sh <= {pump_sh[3:0], pump_enable_in};
		end
	end
	// Limit only while switch closed, drops with it
	assign current_limit_out = switch_on_in &&
		(on_cnt >= (slow_in ? 4'h6 : 4'h2));
	// Ringing makes comparator high during on time; off time is true
	assign eoc_compare_out   = switch_on_in || (pulses >= target_in);
	// Pump output reaches its level five cycles after enable
	assign pump_good_out     = pump_sh[4] && pump_enable_in;
endmodule : fcc_analog_model

/* File: fcc_top_tb.sv */
// Testbench of the flash charge control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
	end end
module fcc_top_tb;
	import fcc_pkg::*;
	localparam logic [31:0] TMO = 32'd400; // Short pump timeout
	logic mclk_in, rstn_in, charge_request_in, flash_fire_in, slow;
	logic charge_complete_n_out, charge_complete_n_oe_out;
	logic current_limit_in, eoc_compare_in, pump_good_in;
	logic switch_on_out, pump_enable_out, switch_gate_drive_out, irq_out;
	logic [4:0] trim_code_out;
	logic [7:0] target, s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int mismatches, n_tests, rises, hits, pulse_cnt;
	time t_req;

	// Design and analog partner
	fcc_top #(.TIMEOUT(TMO)) dut_u (.mclk_in, .rstn_in, .charge_request_in,
		.flash_fire_in, .charge_complete_n_out, .charge_complete_n_oe_out,
		.current_limit_in, .eoc_compare_in, .pump_good_in, .switch_on_out,
		.pump_enable_out, .switch_gate_drive_out, .trim_code_out,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .irq_out);
	fcc_analog_model model_u (.mclk_in, .rstn_in,
		.switch_on_in(switch_on_out), .pump_enable_in(pump_enable_out),
		.slow_in(slow), .target_in(target),
		.current_limit_out(current_limit_in),
		.eoc_compare_out(eoc_compare_in), .pump_good_out(pump_good_in));

	////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	// Closing report, the single end of the run
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// Bounded wait ran out
	task automatic give_up(input string what);
		mismatches++;
		$display("MISMATCH %s exp answer got timeout", what);
		print_verdict();
	endtask : give_up

	// Let a number of clock edges pass
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : tick

	// One AXI4-Lite write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_in);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hF;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge mclk_in);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 100)
			give_up("write response");
	endtask : axi_wr

	// One AXI4-Lite read
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge mclk_in);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge mclk_in);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd  = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 100)
			give_up("read data");
	endtask : axi_rd

	// Raise request and count switch pulses until completion pulls low
	task automatic charge_until_done();
		int n;
		@(posedge mclk_in);
		charge_request_in <= 1'b1;
		t_req = $time;
		rises = pulse_cnt;
		for (n = 0; n < 3000 && !charge_complete_n_oe_out; n++) begin
			@(posedge mclk_in);
		end
		if (n == 3000)
			give_up("charge complete");
	endtask : charge_until_done

	// Pulse counter watching the switch output
	logic sw_d;
	always @(posedge mclk_in) begin
		sw_d <= switch_on_out;
		if (switch_on_out && !sw_d)
			pulse_cnt <= pulse_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{charge_request_in, flash_fire_in, slow} = 3'b010;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h0;
		target = 8'h03;
		rstn_in = 1'b0;
		repeat (5) @(posedge mclk_in);
		rstn_in <= 1'b1;
		tick(20);
		// Idle after reset: pump stopped, gate held off despite fire
		`CHK("pump idle", 1'b0, pump_enable_out)
		`CHK("gate idle", 1'b0, switch_gate_drive_out)
		`CHK("no switching", 1'b0, switch_on_out)
		`CHK("trim reset", TRIM_RST, trim_code_out)
		axi_wr(OFS_IRQ_MASK, 32'h0000_0007);
		$display("test reset done");
		// Charge: 2 pulses below threshold, then 8 detections
		charge_until_done();
		`CHK("pulses to done", 32'd10, pulse_cnt - rises)
		`CHK("done pin", 1'b0, charge_complete_n_oe_out ?
			charge_complete_n_out : 1'b1)
		`CHK("done irq", 1'b1, irq_out)
		`CHK("pump running", 1'b1, pump_enable_out)
		`CHK("gate follows", 1'b1, switch_gate_drive_out)
		flash_fire_in <= 1'b0;
		rises = pulse_cnt;
		tick(40);
		`CHK("no pulses while done", 32'd0, pulse_cnt - rises)
		`CHK("gate released", 1'b0, switch_gate_drive_out)
		axi_wr(OFS_IRQ_STAT, 32'h0000_0001);
		`CHK("irq cleared", 1'b0, irq_out)
		charge_request_in <= 1'b0;
		tick(2);
		`CHK("done released", 1'b0, charge_complete_n_oe_out)
		tick(30);
		`CHK("no pulses idle", 32'd0, pulse_cnt - rises)
		$display("test charge done");
		// Pump timeout runs out and stays stopped
		flash_fire_in <= 1'b1;
		for (hits = 0; hits < 1000 && pump_enable_out; hits++)
			@(posedge mclk_in);
		if (hits == 1000)
			give_up("pump timeout");
		`CHK("timeout span", 1'b1, ($time - t_req) / 10 >= TMO - 4 &&
			($time - t_req) / 10 <= TMO + 4)
		tick(50);
		`CHK("pump stopped", 1'b0, pump_enable_out)
		`CHK("gate off no pump", 1'b0, switch_gate_drive_out)
		axi_rd(OFS_IRQ_STAT);
		`CHK("timeout irq", 1'b1, rd[IRQ_TIMEOUT])
		axi_wr(OFS_IRQ_STAT, 32'h0000_0002);
		$display("test timeout done");
		// Recharge with a slow converter, already at threshold
		slow <= 1'b1;
		charge_until_done();
		`CHK("recharge pulses", 32'd8, pulse_cnt - rises)
		`CHK("pump restarted", 1'b1, pump_enable_out)
		charge_request_in <= 1'b0;
		axi_wr(OFS_IRQ_STAT, 32'h0000_0007);
		$display("test recharge done");
		// Trim: locked, unlocked, programmed, fused
		axi_wr(OFS_TRIM, 32'h0000_0005);
		`CHK("locked trim", TRIM_RST, trim_code_out)
		axi_wr(OFS_UNLOCK, UNLOCK_KEY);
		axi_rd(OFS_STATUS);
		`CHK("unlocked", 1'b1, rd[ST_UNLOCKED])
		axi_wr(OFS_TRIM, 32'h0000_0005);
		`CHK("trim set", 5'h05, trim_code_out)
		`CHK("trim write okay", RESP_OKAY, rsp)
		axi_wr(OFS_CTRL, 32'h0000_0001);
		axi_rd(OFS_IRQ_STAT);
		`CHK("programmed", 1'b1, rd[IRQ_TRIMMED])
		axi_wr(OFS_CTRL, 32'h0000_0002);
		axi_wr(OFS_UNLOCK, UNLOCK_KEY);
		axi_rd(OFS_STATUS);
		`CHK("fused", 1'b1, rd[ST_FUSED])
		`CHK("no reentry", 1'b0, rd[ST_UNLOCKED])
		axi_rd(8'h3C);
		`CHK("unmapped", RESP_SLVERR, rsp)
		$display("test trim done");
		print_verdict();
	end
endmodule : fcc_top_tb
